// ==== hdl/desc_attr_regs.v ====
// Descriptor attribute and transmit FIFO pointer debug registers on AXI4-Lite.
//
// Function
// - Bits 26:16 of the pointer debug register read the live TX FIFO read pointer in DWORDs, zero after reset.
// - Bits 10:0 read the live TX FIFO write pointer in DWORDs, zero after reset, with bits 31:27 and 15:11 reading zero.
// - The attribute registers steer the device only while no EEPROM is fitted and emulation is selected.
// - The attribute registers are guarded by reset protection and keep their contents over a soft reset while it is on.
// - The high-speed register holds a read/write poll interval in bits 23:16 resetting to 04h, bits 31:24 read-only zero.
// - The high-speed register holds read/write device and configuration lengths in bits 15:8 and 7:0 resetting to zero.
// - The full-speed register holds a read/write poll interval in bits 23:16 resetting to 01h, bits 31:24 read-only zero.
// - The full-speed register holds read/write device and configuration lengths in bits 15:8 and 7:0 resetting to zero.
// - The string register holds four read/write byte lengths for configuration, serial, product and maker strings.
//
// Local design decision: the AXI4-Lite register port.
`timescale 1ns/1ps
`default_nettype none
`include "desc_attr_regs_defines.vh"

module desc_attr_regs (
  // Clock and reset.
  input wire clk_in,
  input wire rst_in,
  // Soft reset of the bridge, filtered by reset protection.
  input wire soft_reset_in,
  // AXI4-Lite write address channel.
  input wire s_axi_awvalid_in,
  output reg s_axi_awready_out,
  input wire [`ADDR_W-1:0] s_axi_awaddr_in,
  // AXI4-Lite write data channel.
  input wire s_axi_wvalid_in,
  output reg s_axi_wready_out,
  input wire [31:0] s_axi_wdata_in,
  input wire [3:0] s_axi_wstrb_in,
  // AXI4-Lite write response channel.
  output reg s_axi_bvalid_out,
  input wire s_axi_bready_in,
  output reg [1:0] s_axi_bresp_out,
  // AXI4-Lite read address channel.
  input wire s_axi_arvalid_in,
  output reg s_axi_arready_out,
  input wire [`ADDR_W-1:0] s_axi_araddr_in,
  // AXI4-Lite read data channel.
  output reg s_axi_rvalid_out,
  input wire s_axi_rready_in,
  output reg [31:0] s_axi_rdata_out,
  output reg [1:0] s_axi_rresp_out,
  // Transmit FIFO pointers and EEPROM detection.
  input wire [`PTR_W-1:0] tx_read_pointer_in,
  input wire [`PTR_W-1:0] tx_write_pointer_in,
  input wire eeprom_present_in,
  // Descriptor request from the USB device core.
  input wire desc_req_valid_in,
  input wire [2:0] desc_req_type_in,
  output reg desc_ans_valid_out,
  output reg [7:0] desc_len_out,
  output reg desc_present_out,
  // Settings applied to the USB core.
  output reg emulation_active_out,
  output reg [7:0] high_speed_poll_interval_out,
  output reg [7:0] full_speed_poll_interval_out
);

  ////////////////////////////////////////////////////////////////////////////
  reg [`PTR_W-1:0] rd_ptr_q;
  reg [`PTR_W-1:0] wr_ptr_q;
  reg [31:0] hs_q;
  reg [31:0] fs_q;
  reg [31:0] str_q;
  reg emu_sel_q;
  reg protect_q;
  reg eeprom_q;
  reg aw_full_q;
  reg w_full_q;
  reg [`ADDR_W-1:0] aw_addr_q;
  reg [31:0] w_data_q;
  reg [3:0] w_strb_q;

  wire aw_take;
  wire w_take;
  wire ar_take;
  wire do_write;
  wire b_done;
  wire r_done;
  wire emu_active;
  wire [31:0] byte_mask;
  wire [31:0] wdata_m;
  wire attr_clear;

  assign aw_take = s_axi_awvalid_in & s_axi_awready_out;
  assign w_take = s_axi_wvalid_in & s_axi_wready_out;
  assign ar_take = s_axi_arvalid_in & s_axi_arready_out;
  assign do_write = aw_full_q & w_full_q & ~s_axi_bvalid_out;
  assign b_done = s_axi_bvalid_out & s_axi_bready_in;
  assign r_done = s_axi_rvalid_out & s_axi_rready_in;
  // A soft reset clears the attributes only when protection is off.
  assign attr_clear = soft_reset_in & ~protect_q;
  // The attributes count only with no EEPROM and emulation selected.
  assign emu_active = emu_sel_q & ~eeprom_q;

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi = gi + 1)
    begin : g_lane
      assign byte_mask[8*gi+7:8*gi] = {8{w_strb_q[gi]}};
    end
  endgenerate
  assign wdata_m = w_data_q & byte_mask;

  ////////////////////////////////////////////////////////////////////////////
  // Pointer and EEPROM samples; the live values change every cycle.
  always @(posedge clk_in)
  begin
    if (rst_in)
    begin
      rd_ptr_q <= `PTR_RST;
      wr_ptr_q <= `PTR_RST;
      eeprom_q <= 1'b0;
    end
    else
    begin
      rd_ptr_q <= tx_read_pointer_in;
      wr_ptr_q <= tx_write_pointer_in;
      eeprom_q <= eeprom_present_in;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Write channels: address and data are held independently until both are in.
  always @(posedge clk_in)
  begin
    if (rst_in)
    begin
      aw_full_q <= 1'b0;
      w_full_q <= 1'b0;
      aw_addr_q <= {`ADDR_W{1'b0}};
      w_data_q <= 32'h0000_0000;
      w_strb_q <= 4'h0;
      s_axi_awready_out <= 1'b0;
      s_axi_wready_out <= 1'b0;
      s_axi_bvalid_out <= 1'b0;
      s_axi_bresp_out <= `RESP_OKAY;
    end
    else
    begin
      if (aw_take)
      begin
        aw_full_q <= 1'b1;
        aw_addr_q <= s_axi_awaddr_in;
      end
      else if (b_done)
        aw_full_q <= 1'b0;
      if (w_take)
      begin
        w_full_q <= 1'b1;
        w_data_q <= s_axi_wdata_in;
        w_strb_q <= s_axi_wstrb_in;
      end
      else if (b_done)
        w_full_q <= 1'b0;
      s_axi_awready_out <= ~aw_full_q & ~aw_take & ~s_axi_bvalid_out;
      s_axi_wready_out <= ~w_full_q & ~w_take & ~s_axi_bvalid_out;
      if (do_write)
      begin
        s_axi_bvalid_out <= 1'b1;
        case (aw_addr_q)
          `OFS_HS_LENGTHS, `OFS_FS_LENGTHS, `OFS_STR_LENGTHS_A,
          `OFS_EMU_CTRL, `OFS_TX_FIFO_PTR:
            s_axi_bresp_out <= `RESP_OKAY;
          default:
            s_axi_bresp_out <= `RESP_SLVERR;
        endcase
      end
      else if (b_done)
        s_axi_bvalid_out <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Attribute and control registers; reserved bits are masked off on write.
  always @(posedge clk_in)
  begin
    if (rst_in | attr_clear)
    begin
      hs_q <= {`RSVD_RST, `HS_POLL_RST, `LEN_RST, `LEN_RST};
      fs_q <= {`RSVD_RST, `FS_POLL_RST, `LEN_RST, `LEN_RST};
      str_q <= {`LEN_RST, `LEN_RST, `LEN_RST, `LEN_RST};
    end
    else if (do_write)
    begin
      // Lengths other than zero or 12h are stored as written; policing
      // them would hide a driver fault rather than fix it.
      if (aw_addr_q == `OFS_HS_LENGTHS)
        hs_q <= ((hs_q & ~byte_mask) | wdata_m) & `ATTR_RW_MASK;
      if (aw_addr_q == `OFS_FS_LENGTHS)
        fs_q <= ((fs_q & ~byte_mask) | wdata_m) & `ATTR_RW_MASK;
      if (aw_addr_q == `OFS_STR_LENGTHS_A)
        str_q <= ((str_q & ~byte_mask) | wdata_m) & `STR_RW_MASK;
    end
  end

  always @(posedge clk_in)
  begin
    if (rst_in)
    begin
      emu_sel_q <= 1'b0;
      protect_q <= 1'b0;
    end
    else if (do_write && aw_addr_q == `OFS_EMU_CTRL && w_strb_q[0])
    begin
      emu_sel_q <= w_data_q[`EMU_SEL_BIT];
      protect_q <= w_data_q[`PROTECT_BIT];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read channel: data is registered on the edge that takes the address.
  reg [31:0] rd_mux;
  reg rd_hit;

  always @*
  begin
    rd_mux = 32'h0000_0000;
    rd_hit = 1'b1;
    case (s_axi_araddr_in)
      `OFS_TX_FIFO_PTR:
      begin
        rd_mux[`RD_PTR_LSB+`PTR_W-1:`RD_PTR_LSB] = rd_ptr_q;
        rd_mux[`WR_PTR_LSB+`PTR_W-1:`WR_PTR_LSB] = wr_ptr_q;
      end
      `OFS_HS_LENGTHS:
        rd_mux = hs_q;
      `OFS_FS_LENGTHS:
        rd_mux = fs_q;
      `OFS_STR_LENGTHS_A:
        rd_mux = str_q;
      `OFS_EMU_CTRL:
      begin
        rd_mux[`EMU_SEL_BIT] = emu_sel_q;
        rd_mux[`PROTECT_BIT] = protect_q;
        rd_mux[`EEPROM_SEEN_BIT] = eeprom_q;
      end
      default:
        rd_hit = 1'b0;
    endcase
  end

  always @(posedge clk_in)
  begin
    if (rst_in)
    begin
      s_axi_arready_out <= 1'b0;
      s_axi_rvalid_out <= 1'b0;
      s_axi_rdata_out <= 32'h0000_0000;
      s_axi_rresp_out <= `RESP_OKAY;
    end
    else
    begin
      s_axi_arready_out <= ~ar_take & ~(s_axi_rvalid_out & ~s_axi_rready_in);
      if (ar_take)
      begin
        s_axi_rvalid_out <= 1'b1;
        s_axi_rdata_out <= rd_mux;
        s_axi_rresp_out <= rd_hit ? `RESP_OKAY : `RESP_SLVERR;
      end
      else if (r_done)
        s_axi_rvalid_out <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Descriptor length lookup for the USB core.
  reg [7:0] req_len;

  always @*
  begin
    req_len = `LEN_RST;
    case (desc_req_type_in)
      `REQ_HS_DEV:
        req_len = hs_q[`DEV_MSB:`DEV_LSB];
      `REQ_HS_CFG:
        req_len = hs_q[`CFG_MSB:`CFG_LSB];
      `REQ_FS_DEV:
        req_len = fs_q[`DEV_MSB:`DEV_LSB];
      `REQ_FS_CFG:
        req_len = fs_q[`CFG_MSB:`CFG_LSB];
      `REQ_MAKER_STR:
        req_len = str_q[`STR_MAKER_LSB +: `LEN_W];
      `REQ_PROD_STR:
        req_len = str_q[`STR_PROD_LSB +: `LEN_W];
      `REQ_SERIAL_STR:
        req_len = str_q[`STR_SERIAL_LSB +: `LEN_W];
      `REQ_CONFIG_STR:
        req_len = str_q[`STR_CONFIG_LSB +: `LEN_W];
      default:
        req_len = `LEN_RST;
    endcase
  end

  always @(posedge clk_in)
  begin
    if (rst_in)
    begin
      desc_ans_valid_out <= 1'b0;
      desc_len_out <= `LEN_RST;
      desc_present_out <= 1'b0;
      emulation_active_out <= 1'b0;
      high_speed_poll_interval_out <= `LEN_RST;
      full_speed_poll_interval_out <= `LEN_RST;
    end
    else
    begin
      desc_ans_valid_out <= desc_req_valid_in;
      if (desc_req_valid_in)
      begin
        // Without emulation every length reads zero, so nothing is served.
        desc_len_out <= emu_active ? req_len : `LEN_RST;
        desc_present_out <= emu_active && (req_len != `LEN_RST);
      end
      emulation_active_out <= emu_active;
      high_speed_poll_interval_out <=
        emu_active ? hs_q[`POLL_MSB:`POLL_LSB] : `LEN_RST;
      full_speed_poll_interval_out <=
        emu_active ? fs_q[`POLL_MSB:`POLL_LSB] : `LEN_RST;
    end
  end

endmodule

`default_nettype wire

// ==== hdl/desc_attr_regs_defines.vh ====
// Offsets, field positions, reset values and codes of the attribute register bank.
`ifndef DESC_ATTR_REGS_DEFINES_VH
`define DESC_ATTR_REGS_DEFINES_VH

`define ADDR_W 8
`define OFS_TX_FIFO_PTR 8'h7C
`define OFS_HS_LENGTHS 8'hA0
`define OFS_FS_LENGTHS 8'hA4
`define OFS_STR_LENGTHS_A 8'hA8
`define OFS_EMU_CTRL 8'hC0

`define PTR_W 11
`define RD_PTR_LSB 16
`define WR_PTR_LSB 0
`define PTR_RST 11'h000

`define POLL_MSB 23
`define POLL_LSB 16
`define DEV_MSB 15
`define DEV_LSB 8
`define CFG_MSB 7
`define CFG_LSB 0
`define HS_POLL_RST 8'h04
`define FS_POLL_RST 8'h01
`define LEN_RST 8'h00
`define LEN_W 8
`define RSVD_RST 8'h00
`define STR_MAKER_LSB 0
`define STR_PROD_LSB 8
`define STR_SERIAL_LSB 16
`define STR_CONFIG_LSB 24
`define ATTR_RW_MASK 32'h00FF_FFFF
`define STR_RW_MASK 32'hFFFF_FFFF

`define EMU_SEL_BIT 0
`define PROTECT_BIT 1
`define EEPROM_SEEN_BIT 8

`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`define REQ_HS_DEV 3'h0
`define REQ_HS_CFG 3'h1
`define REQ_FS_DEV 3'h2
`define REQ_FS_CFG 3'h3
`define REQ_MAKER_STR 3'h4
`define REQ_PROD_STR 3'h5
`define REQ_SERIAL_STR 3'h6
`define REQ_CONFIG_STR 3'h7

`endif

// ==== verif/desc_attr_regs_monitor.sv ====
// Concurrent checks on the ports of the attribute register bank.
`timescale 1ns/1ps
`default_nettype none
module desc_attr_regs_monitor (
  // Clock and reset.
  input wire logic clk_in,
  input wire logic rst_in,
  // Bus handshakes.
  input wire logic s_axi_awready_out,
  input wire logic s_axi_bvalid_out,
  input wire logic s_axi_bready_in,
  input wire logic [1:0] s_axi_bresp_out,
  input wire logic s_axi_rvalid_out,
  input wire logic s_axi_rready_in,
  // Descriptor and emulation side.
  input wire logic eeprom_present_in,
  input wire logic desc_req_valid_in,
  input wire logic desc_ans_valid_out,
  input wire logic [7:0] desc_len_out,
  input wire logic desc_present_out,
  input wire logic emulation_active_out,
  input wire logic [7:0] high_speed_poll_interval_out,
  input wire logic [7:0] full_speed_poll_interval_out
);
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (rst_in);
  ////////////////////////////////////////
  property p_ans;
    desc_req_valid_in |=> desc_ans_valid_out;
  endproperty
  a_ans: assert property (p_ans) else $error("answer missing");
  property p_noans;
    !desc_req_valid_in |=> !desc_ans_valid_out;
  endproperty
  a_noans: assert property (p_noans) else $error("stray answer");
  property p_absent;
    desc_ans_valid_out |-> desc_present_out == (desc_len_out != 8'h00);
  endproperty
  a_absent: assert property (p_absent) else $error("presence wrong");
  // The sample register and the flag register together cost two cycles of eeprom history.
  property p_emu;
    emulation_active_out && !$past(rst_in, 2) |->
      !$past(eeprom_present_in, 2);
  endproperty
  a_emu: assert property (p_emu) else $error("emulation with eeprom");
  property p_hs_poll;
    !emulation_active_out && !$past(emulation_active_out) |->
      high_speed_poll_interval_out == 8'h00;
  endproperty
  a_hs_poll: assert property (p_hs_poll) else $error("hs poll leak");
  property p_fs_poll;
    !emulation_active_out && !$past(emulation_active_out) |->
      full_speed_poll_interval_out == 8'h00;
  endproperty
  a_fs_poll: assert property (p_fs_poll) else $error("fs poll leak");
  property p_eeprom;
    eeprom_present_in [*3] ##1 desc_ans_valid_out |->
      desc_len_out == 8'h00 && !desc_present_out;
  endproperty
  a_eeprom: assert property (p_eeprom) else $error("length leak");
  property p_brefuse;
    s_axi_bvalid_out |-> !s_axi_awready_out;
  endproperty
  a_brefuse: assert property (p_brefuse) else $error("aw taken early");
  property p_bdone;
    s_axi_bvalid_out && s_axi_bready_in |=> !s_axi_bvalid_out;
  endproperty
  a_bdone: assert property (p_bdone) else $error("bvalid stuck");
  property p_rdone;
    s_axi_rvalid_out && s_axi_rready_in |=> !s_axi_rvalid_out;
  endproperty
  a_rdone: assert property (p_rdone) else $error("rvalid stuck");
  cover property (desc_req_valid_in && emulation_active_out);
  cover property (desc_ans_valid_out && desc_present_out);
  cover property (s_axi_bvalid_out && s_axi_bresp_out == 2'h2);
endmodule
bind desc_attr_regs desc_attr_regs_monitor i_mon (.clk_in(clk_in),
  .rst_in(rst_in), .s_axi_awready_out(s_axi_awready_out),
  .s_axi_bvalid_out(s_axi_bvalid_out), .s_axi_bready_in(s_axi_bready_in),
  .s_axi_bresp_out(s_axi_bresp_out), .s_axi_rvalid_out(s_axi_rvalid_out),
  .s_axi_rready_in(s_axi_rready_in), .eeprom_present_in(eeprom_present_in),
  .desc_req_valid_in(desc_req_valid_in),
  .desc_ans_valid_out(desc_ans_valid_out), .desc_len_out(desc_len_out),
  .desc_present_out(desc_present_out),
  .emulation_active_out(emulation_active_out),
  .high_speed_poll_interval_out(high_speed_poll_interval_out),
  .full_speed_poll_interval_out(full_speed_poll_interval_out));
`default_nettype wire

// ==== verif/desc_attr_regs_bench.sv ====
// Self-checking bench for the attribute register bank.
`timescale 1ns/1ps
`default_nettype none
module desc_attr_regs_bench;
  logic clk_in, rst_in, soft_reset_in, aw_v, w_v, ar_v, eep, dq_v;
  logic aw_r, w_r, b_v, ar_r, r_v, da_v, dp, emu;
  logic [7:0] aw_a, ar_a, dl, hsp, fsp, ln;
  logic [31:0] w_d, r_d, hs, fs, st, c0, rnd, d;
  logic [63:0] v;
  logic [3:0] w_s;
  logic [1:0] b_r, r_r;
  logic [10:0] rp, wp;
  logic [2:0] dq_t;
  logic [33:0] rq[$];
  logic [1:0] bq[$];
  logic [8:0] dqq[$];
  int failures, n_checks;
  // Ready inputs stay high, so every valid seen is also a handshake.
  desc_attr_regs i_dut (.clk_in(clk_in), .rst_in(rst_in),
    .soft_reset_in(soft_reset_in), .s_axi_awvalid_in(aw_v),
    .s_axi_awready_out(aw_r), .s_axi_awaddr_in(aw_a),
    .s_axi_wvalid_in(w_v), .s_axi_wready_out(w_r), .s_axi_wdata_in(w_d),
    .s_axi_wstrb_in(w_s), .s_axi_bvalid_out(b_v), .s_axi_bready_in(1'b1),
    .s_axi_bresp_out(b_r), .s_axi_arvalid_in(ar_v),
    .s_axi_arready_out(ar_r), .s_axi_araddr_in(ar_a),
    .s_axi_rvalid_out(r_v), .s_axi_rready_in(1'b1), .s_axi_rdata_out(r_d),
    .s_axi_rresp_out(r_r), .tx_read_pointer_in(rp),
    .tx_write_pointer_in(wp), .eeprom_present_in(eep),
    .desc_req_valid_in(dq_v), .desc_req_type_in(dq_t),
    .desc_ans_valid_out(da_v), .desc_len_out(dl), .desc_present_out(dp),
    .emulation_active_out(emu), .high_speed_poll_interval_out(hsp),
    .full_speed_poll_interval_out(fsp));
  ////////////////////////////////////////
  task automatic chk(input string nm, input logic [33:0] s,
    input logic [33:0] e);
    n_checks++;
    if (s !== e)
    begin
      failures++;
      $display("Error %s expected %h seen %h", nm, e, s);
    end
  endtask
  task stop_test;
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task wr(input logic [7:0] a, input logic [31:0] dd, input logic [3:0] s,
    input logic [1:0] r);
    bq.push_back(r);
    aw_a <= a;
    w_d <= dd;
    w_s <= s;
    aw_v <= 1'b1;
    w_v <= 1'b1;
    do
    begin
      @(posedge clk_in);
      if (aw_r)
        aw_v <= 1'b0;
      if (w_r)
        w_v <= 1'b0;
    end while (!b_v);
  endtask
  task rd(input logic [7:0] a, input logic [33:0] e);
    rq.push_back(e);
    ar_a <= a;
    ar_v <= 1'b1;
    do
    begin
      @(posedge clk_in);
      if (ar_r)
        ar_v <= 1'b0;
    end while (!r_v);
  endtask
  task rd_all;
    rd(8'hA0, {2'h0, hs});
    rd(8'hA4, {2'h0, fs});
    rd(8'hA8, {2'h0, st});
    rd(8'hC0, {2'h0, c0});
  endtask
  // All eight request codes go back to back, one per cycle.
  task dreq;
    v = {st, fs[7:0], fs[15:8], hs[7:0], hs[15:8]};
    for (int t = 0; t < 8; t++)
    begin
      ln = (c0[0] && !eep) ? v[t*8 +: 8] : 8'h00;
      dqq.push_back({ln != 8'h00, ln});
      dq_v <= 1'b1;
      dq_t <= t[2:0];
      @(posedge clk_in);
    end
    dq_v <= 1'b0;
  endtask
  ////////////////////////////////////////
  always @(posedge clk_in)
  begin
    if (r_v)
      chk("read", {r_r, r_d}, rq.pop_front());
    if (b_v)
      chk("bresp", {32'h0, b_r}, {32'h0, bq.pop_front()});
    if (da_v)
      chk("desc", {25'h0, dp, dl}, {25'h0, dqq.pop_front()});
  end
  initial
  begin
    clk_in = 1'b0;
    forever
      #2 clk_in = ~clk_in;
  end
  initial
  begin
    #20000;
    failures++;
    stop_test;
  end
  initial
  begin
    rst_in = 1'b1;
    {soft_reset_in, aw_v, w_v, ar_v, eep, dq_v} = 6'h00;
    {aw_a, ar_a, w_d, w_s, dq_t, rp, wp} = '0;
    hs = 32'h00040000;
    fs = 32'h00010000;
    st = 32'h0;
    c0 = 32'h0;
    rnd = $urandom(3618);
    repeat (6) @(posedge clk_in);
    rst_in <= 1'b0;
    rnd = $urandom;
    rp <= rnd[10:0];
    wp <= rnd[26:16];
    @(posedge clk_in);
    d = {5'h00, rnd[10:0], 5'h00, rnd[26:16]};
    rd(8'h7C, {2'h0, d});
    rd_all;
    wr(8'h7C, rnd, 4'hF, 2'h0);
    rd(8'h7C, {2'h0, d});
    wr(8'h80, rnd, 4'hF, 2'h2);
    rd(8'h80, {2'h2, 32'h0});
    repeat (3)
    begin
      rnd = $urandom;
      d = {rnd[31:16], rnd[0] ? 8'h12 : 8'h00,
        rnd[1] ? 8'h12 : 8'h00};
      wr(8'hA0, d, 4'hF, 2'h0);
      hs = d & 32'h00FFFFFF;
      d = {rnd[15:0], rnd[2] ? 8'h12 : 8'h00,
        rnd[3] ? 8'h12 : 8'h00};
      wr(8'hA4, d, 4'hF, 2'h0);
      fs = d & 32'h00FFFFFF;
      for (int b = 0; b < 4; b++)
        if (rnd[b + 4])
          st[b*8 +: 8] = rnd[b*8 +: 8];
      wr(8'hA8, rnd, rnd[7:4], 2'h0);
      rd_all;
    end
    wr(8'hC0, 32'h1, 4'hF, 2'h0);
    c0 = 32'h1;
    repeat (3) @(posedge clk_in);
    chk("hs poll", {26'h0, hsp}, {26'h0, hs[23:16]});
    chk("fs poll", {26'h0, fsp}, {26'h0, fs[23:16]});
    chk("emu", {33'h0, emu}, 34'h1);
    dreq;
    eep <= 1'b1;
    repeat (3) @(posedge clk_in);
    chk("hs poll", {26'h0, hsp}, 34'h0);
    chk("fs poll", {26'h0, fsp}, 34'h0);
    chk("emu", {33'h0, emu}, 34'h0);
    // Reading is allowed while the EEPROM is fitted; the next write is made after it is removed.
    rd(8'hC0, {2'h0, 32'h0000_0101});
    dreq;
    eep <= 1'b0;
    wr(8'hC0, 32'h3, 4'hF, 2'h0);
    c0 = 32'h3;
    soft_reset_in <= 1'b1;
    @(posedge clk_in);
    soft_reset_in <= 1'b0;
    rd_all;
    wr(8'hC0, 32'h1, 4'hF, 2'h0);
    c0 = 32'h1;
    soft_reset_in <= 1'b1;
    @(posedge clk_in);
    soft_reset_in <= 1'b0;
    hs = 32'h00040000;
    fs = 32'h00010000;
    st = 32'h0;
    rd_all;
    stop_test;
  end
endmodule
`default_nettype wire
